// [src/csde_map.vh]
// Constants for the compare, skip, decimal adjust and decrement execution block
`ifndef CSDE_MAP_VH
`define CSDE_MAP_VH

// Opcode fields
`define CSDE_OP_CMP_HI      8'h32
`define CSDE_OP_CMP_LO      8'h30
`define CSDE_OP_CMP_EQ      8'h31
`define CSDE_OP_DADJ        7'h17
`define CSDE_OP_DECR        7'h03
`define CSDE_SEL_BIT        8
`define CSDE_ADDR_MSB       7

// Decimal adjust constants
`define CSDE_BCD_LIMIT      4'h9
`define CSDE_BCD_CORR       4'h6

// Instruction cycle phases
`define CSDE_Q1             2'h0
`define CSDE_Q2             2'h1
`define CSDE_Q3             2'h2
`define CSDE_Q4             2'h3

// Flag bit positions
`define CSDE_FLG_C          0
`define CSDE_FLG_HCY        1
`define CSDE_FLG_Z          2
`define CSDE_FLG_WRAP       3

// Register byte offsets
`define CSDE_OFF_WACC       4'h0
`define CSDE_OFF_FLAGS      4'h4
`define CSDE_OFF_CTRL       4'h8
`define CSDE_OFF_STATE      4'hc

// Reset values
`define CSDE_RST_WACC       8'h00
`define CSDE_RST_FLAGS      4'h0
`define CSDE_RST_CTRL       1'b1

`endif

// [src/csde_bcd_nibble.v]
// One nibble of the decimal adjust: add six when above nine or when forced
`include "csde_map.vh"

module csde_bcd_nibble
(
	// Nibble in
	input  wire [3:0] nib_i,
	input  wire       force_i,
	// Corrected nibble and carry out
	output wire [3:0] nib_o,
	output wire       carry_o
);

	wire       need_corr;
	wire [4:0] sum;

	// Correct when above nine or the matching carry flag is set
	assign need_corr = (nib_i > `CSDE_BCD_LIMIT) | force_i;
	assign sum       = {1'b0, nib_i} + {1'b0, (need_corr ? `CSDE_BCD_CORR : 4'h0)};
	assign nib_o     = sum[3:0];
	assign carry_o   = sum[4];

endmodule // csde_bcd_nibble

// [src/csde_exec.v]
// Execution unit for compare-and-skip, decimal adjust and decrement instructions
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`include "csde_map.vh"

module csde_exec
(
	// Clock, reset, enable
	input  wire        clock_i,
	input  wire        resetn_i,
	input  wire        ce_i,
	// Instruction stream, sampled in Q1
	input  wire [15:0] instr_i,
	input  wire        instr_valid_i,
	// Data memory port
	output reg         reg_rd_o,
	output reg  [7:0]  reg_raddr_o,
	input  wire [7:0]  reg_rdata_i,
	output reg         reg_wr_o,
	output reg  [7:0]  reg_waddr_o,
	output reg  [7:0]  reg_wdata_o,
	// Core state
	output wire [1:0]  q_phase_o,
	output wire        nop_slot_o,
	output wire [7:0]  wacc_o,
	output wire [3:0]  flags_o,
	// Avalon-MM slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest
);

	// Reset synchroniser
	reg        rst_meta_ff;
	reg        rst_sync_ff;
	wire       rstn;

	// Pipeline state
	reg [1:0]  qph_ff;
	reg [15:0] ir_ff;
	reg        ir_live_ff;
	reg        skip_ff;
	reg        nop_ff;
	reg [7:0]  fval_ff;
	reg [7:0]  wacc_ff;
	reg [3:0]  flags_ff;
	reg        run_ff;

	// Bus state
	reg        ack_ff;

	// Decode and datapath
	wire       is_cmp_gt;
	wire       is_cmp_lt;
	wire       is_cmp_eq;
	wire       is_dadj;
	wire       is_decr;
	wire       sel_bit;
	wire [8:0] cmp_diff;
	wire       f_lt_w;
	wire       f_eq_w;
	wire       f_gt_w;
	wire       skip_hit;
	wire [7:0] dec_res;
	wire [3:0] adj_lo;
	wire [3:0] adj_hi;
	wire       adj_hi_cy;
	wire       bus_wr;

	// Next values
	reg  [7:0] nxt_wacc;
	reg  [3:0] nxt_flags;
	reg        nxt_wr;
	reg  [7:0] nxt_wdata;

	// Reset release through two flops
	// Assertion is immediate; release waits two edges so no flop sees a runt release
	always @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	assign rstn = rst_sync_ff;

	// Opcode decode on the held instruction
	assign is_cmp_gt = (ir_ff[15:8] == `CSDE_OP_CMP_HI);
	assign is_cmp_lt = (ir_ff[15:8] == `CSDE_OP_CMP_LO);
	assign is_cmp_eq = (ir_ff[15:8] == `CSDE_OP_CMP_EQ);
	assign is_dadj   = (ir_ff[15:9] == `CSDE_OP_DADJ);
	assign is_decr   = (ir_ff[15:9] == `CSDE_OP_DECR);
	assign sel_bit   = ir_ff[`CSDE_SEL_BIT];

	// Unsigned compare by register minus accumulator
	assign cmp_diff = {1'b0, fval_ff} - {1'b0, wacc_ff};
	assign f_lt_w   = cmp_diff[8];
	assign f_eq_w   = (cmp_diff[7:0] == 8'h00);
	assign f_gt_w   = ~f_lt_w & ~f_eq_w;

	// Skip condition of the compare family
	// Equal shares the subtractor with the two ordering compares
	assign skip_hit = (is_cmp_gt & f_gt_w)
		| (is_cmp_lt & f_lt_w)
		| (is_cmp_eq & f_eq_w);

	// Decrement result
	// Carry means no borrow: only a zero register borrows
	// Overflow marks the single signed wrap, from 0x80 down to 0x7f
	assign dec_res = fval_ff - 8'h01;

	// Nibble-wise decimal correction of the accumulator
	// The nibbles are corrected independently; the low nibble carry is dropped
	csde_bcd_nibble u_adj_lo
	(
		.nib_i   (wacc_ff[3:0]),
		.force_i (flags_ff[`CSDE_FLG_HCY]),
		.nib_o   (adj_lo),
		.carry_o ()
	);

	csde_bcd_nibble u_adj_hi
	(
		.nib_i   (wacc_ff[7:4]),
		.force_i (flags_ff[`CSDE_FLG_C]),
		.nib_o   (adj_hi),
		.carry_o (adj_hi_cy)
	);

	// Bus write strobe, taken in the cycle waitrequest is low
	assign bus_wr = avs_write & ack_ff;

	// Q4 result: destination write, accumulator and flags
	// Execution updates come after the bus writes, so they win in a shared cycle
	always @*
	begin
		nxt_wacc  = wacc_ff;
		nxt_flags = flags_ff;
		nxt_wr    = 1'b0;
		nxt_wdata = 8'h00;
		if (bus_wr && avs_address == `CSDE_OFF_WACC && avs_byteenable[0])
			nxt_wacc = avs_writedata[7:0];
		if (bus_wr && avs_address == `CSDE_OFF_FLAGS && avs_byteenable[0])
			nxt_flags = avs_writedata[3:0];
		if (qph_ff == `CSDE_Q4 && ir_live_ff)
		begin
			if (is_dadj)
			begin
				nxt_wr    = 1'b1;
				nxt_wdata = {adj_hi, adj_lo};
				if (!sel_bit)
					nxt_wacc = {adj_hi, adj_lo};
				if (adj_hi_cy)
					nxt_flags[`CSDE_FLG_C] = 1'b1;
			end
			else if (is_decr)
			begin
				if (sel_bit)
				begin
					nxt_wr    = 1'b1;
					nxt_wdata = dec_res;
				end
				else
					nxt_wacc = dec_res;
				nxt_flags[`CSDE_FLG_C]    = (fval_ff != 8'h00);
				nxt_flags[`CSDE_FLG_HCY]  = (fval_ff[3:0] != 4'h0);
				nxt_flags[`CSDE_FLG_Z]    = (dec_res == 8'h00);
				nxt_flags[`CSDE_FLG_WRAP] = (fval_ff == 8'h80);
			end
		end
	end

	// Four-phase instruction cycle and execution state
	always @(posedge clock_i or negedge rstn)
	begin
		if (!rstn)
		begin
			qph_ff      <= `CSDE_Q1;
			ir_ff       <= 16'h0000;
			ir_live_ff  <= 1'b0;
			skip_ff     <= 1'b0;
			nop_ff      <= 1'b0;
			fval_ff     <= 8'h00;
			wacc_ff     <= `CSDE_RST_WACC;
			flags_ff    <= `CSDE_RST_FLAGS;
			reg_rd_o    <= 1'b0;
			reg_raddr_o <= 8'h00;
			reg_wr_o    <= 1'b0;
			reg_waddr_o <= 8'h00;
			reg_wdata_o <= 8'h00;
		end
		else if (ce_i)
		begin
			qph_ff    <= qph_ff + 2'h1;
			reg_rd_o  <= 1'b0;
			reg_wr_o  <= nxt_wr;
			wacc_ff   <= nxt_wacc;
			flags_ff  <= nxt_flags;
			if (nxt_wr)
			begin
				reg_waddr_o <= ir_ff[`CSDE_ADDR_MSB:0];
				reg_wdata_o <= nxt_wdata;
			end
			case (qph_ff)
				`CSDE_Q1:
				begin
					// A skipped slot runs as a no-operation cycle
					// An invalid word or a stopped core also leaves the slot idle
					ir_ff      <= instr_i;
					ir_live_ff <= instr_valid_i & run_ff & ~skip_ff;
					nop_ff     <= skip_ff;
					skip_ff    <= 1'b0;
				end
				`CSDE_Q2:
				begin
					reg_rd_o    <= ir_live_ff;
					reg_raddr_o <= ir_ff[`CSDE_ADDR_MSB:0];
				end
				`CSDE_Q3:
					fval_ff <= reg_rdata_i;
				default:
				begin
					// Compares write nothing; a hit costs one extra cycle
					skip_ff <= ir_live_ff & skip_hit;
				end
			endcase
		end
	end

	// Control register and bus acknowledge
	// The run bit stops new instructions; one already in flight completes
	always @(posedge clock_i or negedge rstn)
	begin
		if (!rstn)
		begin
			run_ff <= `CSDE_RST_CTRL;
			ack_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			ack_ff <= (avs_read | avs_write) & ~ack_ff;
			if (bus_wr && avs_address == `CSDE_OFF_CTRL && avs_byteenable[0])
				run_ff <= avs_writedata[0];
		end
	end

	// Read data, registered at the acknowledge edge
	// Loaded while waitrequest is high, so the data stands at the accepting edge
	always @(posedge clock_i or negedge rstn)
	begin
		if (!rstn)
			avs_readdata <= 32'h00000000;
		else if (ce_i && (avs_read & ~ack_ff))
		begin
			if (avs_address == `CSDE_OFF_WACC)
				avs_readdata <= {24'h000000, wacc_ff};
			else if (avs_address == `CSDE_OFF_FLAGS)
				avs_readdata <= {28'h0000000, flags_ff};
			else if (avs_address == `CSDE_OFF_CTRL)
				avs_readdata <= {31'h00000000, run_ff};
			else if (avs_address == `CSDE_OFF_STATE)
				avs_readdata <= {12'h000, nop_ff, skip_ff, qph_ff, ir_ff};
			else
				avs_readdata <= 32'h00000000;
		end
	end

	// Waitrequest holds the first cycle of each access
	// The acknowledge flop also keeps a held request from being taken twice
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;

	// Core state outputs
	// Straight from flops, with no logic after the registers
	assign q_phase_o  = qph_ff;
	assign nop_slot_o = nop_ff;
	assign wacc_o     = wacc_ff;
	assign flags_o    = flags_ff;

endmodule // csde_exec

// [verif/csde_exec_monitor.sv]
// Assertion checker for the compare, decimal adjust and decrement block
module csde_exec_monitor
(
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        resetn_i,
	// Instruction and data memory port
	input wire logic [15:0] instr_i,
	input wire logic        reg_rd_o,
	input wire logic [7:0]  reg_raddr_o,
	input wire logic [7:0]  reg_rdata_i,
	input wire logic        reg_wr_o,
	input wire logic [7:0]  reg_waddr_o,
	input wire logic [7:0]  reg_wdata_o,
	// Core state
	input wire logic [1:0]  q_phase_o,
	input wire logic        nop_slot_o,
	input wire logic [7:0]  wacc_o,
	input wire logic [3:0]  flags_o
);
	default clocking mcb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	// A compare instruction reading its register in Q3
	logic cmp;
	assign cmp = reg_rd_o && (instr_i[15:8] == 8'h30 || instr_i[15:8] == 8'h31 || instr_i[15:8] == 8'h32);

	rd_phase_a: assert property (reg_rd_o |-> q_phase_o == 2'h2 && reg_raddr_o == $past(instr_i[7:0], 2))
		else $error("register read out of phase or address");
	wr_pulse_a: assert property (reg_wr_o |-> q_phase_o == 2'h0 ##1 !reg_wr_o)
		else $error("register write not a Q1 pulse");
	cmp_keep_a: assert property (cmp |-> ##2 !reg_wr_o && $stable(wacc_o) && $stable(flags_o))
		else $error("compare changed state");
	skip_gt_a: assert property (reg_rd_o && instr_i[15:8] == 8'h32 && reg_rdata_i > wacc_o |-> ##3 nop_slot_o)
		else $error("greater compare did not skip");
	skip_lt_a: assert property (reg_rd_o && instr_i[15:8] == 8'h30 && reg_rdata_i < wacc_o |-> ##3 nop_slot_o)
		else $error("less compare did not skip");
	no_skip_a: assert property (cmp && instr_i[15:8] != 8'h31 && reg_rdata_i == wacc_o |-> ##3 !nop_slot_o)
		else $error("compare skipped on equal operands");
	dec_res_a: assert property (reg_rd_o && instr_i[15:9] == 7'h03 |-> ##2 ($past(instr_i[8], 2) ?
		reg_wr_o && reg_wdata_o == $past(reg_rdata_i, 2) - 8'h01 :
		!reg_wr_o && wacc_o == $past(reg_rdata_i, 2) - 8'h01))
		else $error("decrement result or destination wrong");
	dec_zero_a: assert property (reg_rd_o && instr_i[15:9] == 7'h03 |-> ##2 flags_o[2] == ($past(reg_rdata_i, 2) == 8'h01))
		else $error("decrement zero flag wrong");
	dadj_dst_a: assert property (reg_rd_o && instr_i[15:9] == 7'h17 |-> ##2 reg_wr_o && reg_waddr_o == $past(instr_i[7:0], 2)
		&& ($past(instr_i[8], 2) || wacc_o == reg_wdata_o))
		else $error("decimal adjust destination wrong");
endmodule // csde_exec_monitor

bind csde_exec csde_exec_monitor mon (.*);

// [verif/csde_exec_tb.sv]
// Self-checking testbench for the compare, decimal adjust and decrement block
module csde_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        ce_i = 1'b1;
	logic [15:0] instr_i = 16'h0000;
	logic        instr_valid_i = 1'b0;
	logic [7:0]  reg_rdata_i = 8'h00;
	logic        reg_rd_o, reg_wr_o, nop_slot_o, avs_waitrequest;
	logic [7:0]  reg_raddr_o, reg_waddr_o, reg_wdata_o, wacc_o;
	logic [1:0]  q_phase_o;
	logic [3:0]  flags_o;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h1;
	logic [31:0] avs_readdata, rd;
	int          n_errors = 0;
	int          n_tests = 0;
	int          cyc = 0;

	csde_exec dut (.*);

	// Clock at 10 MHz
	initial forever #50 clock_i = ~clock_i;

	// Cycle ceiling against hangs
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			n_errors++;
			test_done();
		end
	end

	task test_done();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One bus cycle, held until waitrequest is seen low
	task bus(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock_i);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= !we;
		// Waitrequest is read as it stood at each edge; only the bench timeout ends the wait
		do
		begin
			@(posedge clock_i);
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// One instruction held from Q1 to Q4; returns in the next Q1
	task run(input logic [15:0] op, input logic [7:0] f);
		int k;
		k = 0;
		// Find Q4 from settled outputs, then drive at the edge that ends it
		do
		begin
			@(posedge clock_i);
			#1;
			k++;
		end
		while (q_phase_o !== 2'h3 && k < 8);
		if (q_phase_o !== 2'h3)
			n_errors++;
		@(posedge clock_i);
		instr_i <= op;
		instr_valid_i <= 1'b1;
		reg_rdata_i <= f;
		repeat (4) @(posedge clock_i);
		instr_valid_i <= 1'b0;
		#1;
	endtask

	task setw(input logic [7:0] w, input logic [3:0] fl);
		bus(1'b1, 4'h0, {24'h0, w}, rd);
		bus(1'b1, 4'h4, {28'h0, fl}, rd);
	endtask

	task t_regs();
		bus(1'b0, 4'h0, 32'h0, rd); chk("acc reset", rd, 32'h0);
		bus(1'b0, 4'h4, 32'h0, rd); chk("flags reset", rd, 32'h0);
		bus(1'b0, 4'h8, 32'h0, rd); chk("ctrl reset", rd, 32'h1);
		bus(1'b1, 4'h2, 32'hff, rd);
		bus(1'b0, 4'h2, 32'h0, rd); chk("unmapped", rd, 32'h0);
		bus(1'b1, 4'h0, 32'h3c, rd);
		bus(1'b0, 4'h0, 32'h0, rd); chk("acc rw", rd, 32'h3c);
		// A stopped core leaves an issued decrement idle
		bus(1'b1, 4'h8, 32'h0, rd);
		run(16'h0644, 8'h10);
		chk("stopped acc", wacc_o, 8'h3c);
		chk("stopped flags", flags_o, 4'h0);
		bus(1'b1, 4'h8, 32'h1, rd);
		$display("test registers done");
	endtask

	task t_cmp();
		logic [7:0] op[5] = '{8'h32, 8'h32, 8'h30, 8'h30, 8'h31};
		logic [7:0] f[5] = '{8'h81, 8'h80, 8'h7f, 8'h80, 8'h80};
		logic       sk[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		setw(8'h80, 4'ha);
		for (int i = 0; i < 5; i++)
		begin
			run({op[i], 8'h3c}, f[i]);
			chk("cmp write", reg_wr_o, 1'b0);
			chk("cmp acc", wacc_o, 8'h80);
			chk("cmp flags", flags_o, 4'ha);
			repeat (2) @(posedge clock_i);
			#1 chk("skip", nop_slot_o, sk[i]);
		end
		$display("test compare done");
	endtask

	task t_dadj();
		logic [7:0] w[4] = '{8'ha5, 8'hce, 8'h12, 8'h99};
		logic [3:0] fl[4] = '{4'h0, 4'h0, 4'h2, 4'h1};
		logic [7:0] op[4] = '{8'h2e, 8'h2e, 8'h2e, 8'h2f};
		logic [7:0] res[4] = '{8'h05, 8'h24, 8'h18, 8'hf9};
		logic [7:0] ea[4] = '{8'h05, 8'h24, 8'h18, 8'h99};
		logic [3:0] ef[4] = '{4'h1, 4'h1, 4'h2, 4'h1};
		for (int i = 0; i < 4; i++)
		begin
			setw(w[i], fl[i]);
			run({op[i], 8'h21}, 8'h5a);
			chk("adj write", reg_wr_o, 1'b1);
			chk("adj addr", reg_waddr_o, 8'h21);
			chk("adj data", reg_wdata_o, res[i]);
			chk("adj acc", wacc_o, ea[i]);
			chk("adj flags", flags_o, ef[i]);
		end
		$display("test decimal adjust done");
	endtask

	task t_dec();
		logic [7:0] f[3] = '{8'h01, 8'h80, 8'h00};
		logic [7:0] op[3] = '{8'h07, 8'h06, 8'h06};
		logic       ew[3] = '{1'b1, 1'b0, 1'b0};
		logic [7:0] ea[3] = '{8'h55, 8'h7f, 8'hff};
		logic [3:0] ef[3] = '{4'h7, 4'h9, 4'h0};
		for (int i = 0; i < 3; i++)
		begin
			setw(8'h55, 4'h0);
			run({op[i], 8'h44}, f[i]);
			chk("dec write", reg_wr_o, ew[i]);
			if (ew[i])
			begin
				chk("dec addr", reg_waddr_o, 8'h44);
				chk("dec data", reg_wdata_o, 8'h00);
			end
			chk("dec acc", wacc_o, ea[i]);
			chk("dec flags", flags_o, ef[i]);
		end
		$display("test decrement done");
	endtask

	// Main sequence
	initial
	begin
		repeat (2) @(posedge clock_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		t_regs();
		t_cmp();
		t_dadj();
		t_dec();
		test_done();
	end
endmodule // csde_exec_tb
